// ==== pkg/err_report_consts.svh ====
`ifndef ERR_REPORT_CONSTS_SVH
`define ERR_REPORT_CONSTS_SVH
// What this block does
// - posted error: posted high; device sends Non-Fatal message if enabled
// - completion queue full drops ready; user stops UR and abort strobes
// - disabled messages are suppressed, status bits are always set
// - with AER, severity and mask registers choose messages and severity
// - UR non-posted: UR completion; with AER correctable message if enabled
// - UR posted: no completion; Non-Fatal, or severity-graded with AER
// - abort: CA completion; Non-Fatal, or Correctable/graded with AER by posted
// - advisory errors send nothing without AER, Correctable with AER
// - fatal-capable errors send Non-Fatal, or severity-graded with AER
// - correctable strobe sends Correctable; header overflow counts only with AER
// - malformed sends Fatal without AER, severity-graded with AER

// register byte offsets
`define REG_CTRL 8'h00
`define REG_DEV_STATUS 8'h04
`define REG_UNC_STATUS 8'h08
`define REG_UNC_MASK 8'h0C
`define REG_UNC_SEVERITY 8'h10
`define REG_COR_STATUS 8'h14
`define REG_COR_MASK 8'h18
`define REG_LOG_CTRL 8'h1C
`define REG_HDR_LOG0 8'h20
`define REG_HDR_LOG3 8'h2C

// control register fields
`define CTRL_AER_EN 0
`define CTRL_COR_EN 1
`define CTRL_NF_EN 2
`define CTRL_FATAL_EN 3
`define CTRL_SERR_EN 4
`define CTRL_PWR_LO 8
`define CTRL_PWR_HI 9
`define CTRL_PME_EN 10
`define CTRL_RESET 32'h0000_0000

// device status fields
`define DEV_COR 0
`define DEV_NF 1
`define DEV_FATAL 2
`define DEV_UR 3
`define DEV_PME 4

// uncorrectable status bit positions
`define UNC_POISONED 12
`define UNC_CPL_TIMEOUT 14
`define UNC_CPL_ABORT 15
`define UNC_UNEXP_CPL 16
`define UNC_MALFORMED 18
`define UNC_ECRC 19
`define UNC_UR 20
`define UNC_MC_BLOCKED 23
`define UNC_ATOMIC_BLOCKED 24

// correctable status bit positions
`define COR_ADVISORY 13
`define COR_INTERNAL 14
`define COR_HDR_OVERFLOW 15

`define LOG_SET_BIT 8
`define PWR_D0 2'b00
`define HDR_INFO_W 48
`define HDR_LOG_W 128
`endif

// ==== pkg/err_report_pkg.sv ====
package err_report_pkg;
	typedef enum logic {CPL_UNSUPPORTED, CPL_ABORT} cpl_status_e;
	typedef enum logic [1:0] {MSG_CORRECTABLE, MSG_NONFATAL, MSG_FATAL} msg_kind_e;
	// how an error is turned into a message
	typedef enum logic [2:0] {CLS_NONE, CLS_ADVISORY, CLS_GRADED, CLS_FATAL, CLS_COR} err_class_e;
endpackage : err_report_pkg

// ==== core/err_report.sv ====
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "err_report_consts.svh"
module err_report #(
	parameter int DEPTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic report_unsupported_request,
	input wire logic report_completer_abort,
	input wire logic report_cpl_timeout,
	input wire logic report_unexpected_cpl,
	input wire logic report_atomic_egress_block,
	input wire logic report_multicast_block,
	input wire logic report_ecrc,
	input wire logic report_correctable,
	input wire logic report_malformed,
	input wire logic report_poisoned,
	input wire logic error_posted,
	input wire logic error_no_recovery,
	input wire logic [`HDR_INFO_W-1:0] cpl_header_info,
	input wire logic [`HDR_LOG_W-1:0] tlp_header_log,
	input wire logic wake_request_pulse,
	output logic cpl_ready,
	output logic header_logged,
	output logic [1:0] power_state,
	output logic pme_enable,
	output logic cpl_valid,
	output err_report_pkg::cpl_status_e cpl_status,
	output logic [`HDR_INFO_W-1:0] cpl_header,
	input wire logic cpl_taken,
	output logic msg_valid,
	output err_report_pkg::msg_kind_e msg_kind
);
	import err_report_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);

	logic [31:0] ctrl;
	logic [4:0] dev_status;
	logic [31:0] unc_status;
	logic [31:0] unc_mask;
	logic [31:0] unc_severity;
	logic [31:0] cor_status;
	logic [31:0] cor_mask;
	logic [4:0] first_ptr;
	logic [`HDR_LOG_W-1:0] hdr_log;
	logic [`HDR_INFO_W-1:0] q_hdr [DEPTH];
	cpl_status_e q_kind [DEPTH];
	logic [CW-1:0] count;

	logic aer;
	logic wr_en;
	logic [31:0] w1c;
	logic [31:0] unc_hit;
	logic [31:0] cor_hit;
	logic [4:0] hit_ptr;
	logic [4:0] dev_hit;
	err_class_e cls;
	logic cpl_push;
	cpl_status_e cpl_kind;
	logic msg_send;
	msg_kind_e msg_sel;
	logic push;
	logic pop;
	logic [CW-1:0] wr_idx;
	logic [CW-1:0] next_count;
	logic log_now;
	logic log_clear;

	assign aer = ctrl[`CTRL_AER_EN];
	assign wr_en = psel && penable && pready && pwrite;
	assign w1c = wr_en ? pwdata : 32'h0000_0000;

	// classify the single strobe of this cycle; one strobe per clock assumed
	always_comb
	begin
		unc_hit = 32'h0000_0000;
		cor_hit = 32'h0000_0000;
		cls = CLS_NONE;
		cpl_push = 1'b0;
		cpl_kind = CPL_UNSUPPORTED;
		if (report_unsupported_request)
		begin
			unc_hit[`UNC_UR] = 1'b1;
			if (!error_posted)
			begin
				cpl_push = 1'b1;
				cls = CLS_ADVISORY;
			end
			else
				cls = CLS_GRADED;
		end
		else if (report_completer_abort)
		begin
			unc_hit[`UNC_CPL_ABORT] = 1'b1;
			cpl_push = 1'b1;
			cpl_kind = CPL_ABORT;
			cls = (aer && !error_posted) ? CLS_ADVISORY : CLS_GRADED;
		end
		else if (report_cpl_timeout)
		begin
			unc_hit[`UNC_CPL_TIMEOUT] = 1'b1;
			cls = error_no_recovery ? CLS_GRADED : CLS_ADVISORY;
		end
		else if (report_poisoned)
		begin
			unc_hit[`UNC_POISONED] = 1'b1;
			cls = error_no_recovery ? CLS_GRADED : CLS_ADVISORY;
		end
		else if (report_unexpected_cpl)
		begin
			unc_hit[`UNC_UNEXP_CPL] = 1'b1;
			cls = CLS_ADVISORY;
		end
		else if (report_atomic_egress_block)
		begin
			unc_hit[`UNC_ATOMIC_BLOCKED] = 1'b1;
			cls = CLS_ADVISORY;
		end
		else if (report_ecrc)
		begin
			unc_hit[`UNC_ECRC] = 1'b1;
			cls = CLS_GRADED;
		end
		else if (report_multicast_block)
		begin
			unc_hit[`UNC_MC_BLOCKED] = 1'b1;
			cls = CLS_GRADED;
		end
		else if (report_malformed)
		begin
			unc_hit[`UNC_MALFORMED] = 1'b1;
			cls = CLS_FATAL;
		end
		else if (report_correctable)
		begin
			cor_hit[`COR_INTERNAL] = 1'b1;
			cls = CLS_COR;
		end
		if (cls == CLS_ADVISORY && aer)
			cor_hit[`COR_ADVISORY] = 1'b1;
		// overflow only exists once a header is already held, and only with AER
		if (aer && header_logged && cls != CLS_COR && cls != CLS_NONE)
			cor_hit[`COR_HDR_OVERFLOW] = 1'b1;
	end

	// bit position of the uncorrectable error, for the first error pointer
	always_comb
	begin
		hit_ptr = 5'h00;
		for (int i = 0; i < 32; i++)
			if (unc_hit[i])
				hit_ptr = i[4:0];
	end

	// message choice and status; enables gate messages only, never status
	always_comb
	begin
		msg_send = 1'b0;
		msg_sel = MSG_CORRECTABLE;
		dev_hit = 5'h00;
		dev_hit[`DEV_UR] = unc_hit[`UNC_UR];
		case (cls)
			CLS_ADVISORY:
			begin
				if (aer)
				begin
					dev_hit[`DEV_COR] = 1'b1;
					msg_send = ctrl[`CTRL_COR_EN] && !cor_mask[`COR_ADVISORY];
				end
			end
			CLS_GRADED, CLS_FATAL:
			begin
				if (aer)
				begin
					msg_sel = unc_severity[hit_ptr] ? MSG_FATAL : MSG_NONFATAL;
					msg_send = !unc_mask[hit_ptr];
				end
				else
				begin
					msg_sel = (cls == CLS_FATAL) ? MSG_FATAL : MSG_NONFATAL;
					msg_send = 1'b1;
				end
				if (msg_sel == MSG_FATAL)
				begin
					dev_hit[`DEV_FATAL] = 1'b1;
					msg_send = msg_send && (ctrl[`CTRL_FATAL_EN] || ctrl[`CTRL_SERR_EN]);
				end
				else
				begin
					dev_hit[`DEV_NF] = 1'b1;
					msg_send = msg_send && (ctrl[`CTRL_NF_EN] || ctrl[`CTRL_SERR_EN]);
				end
			end
			CLS_COR:
			begin
				dev_hit[`DEV_COR] = 1'b1;
				msg_send = ctrl[`CTRL_COR_EN] && !(aer && cor_mask[`COR_INTERNAL]);
			end
			default:
			begin
				msg_send = 1'b0;
			end
		endcase
	end

	// message strobe, one cycle per reported error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			msg_valid <= 1'b0;
			msg_kind <= MSG_CORRECTABLE;
		end
		else
		begin
			msg_valid <= msg_send;
			msg_kind <= msg_sel;
		end
	end

	// completion queue; ready is the registered room left after this edge
	assign push = cpl_push && cpl_ready;
	assign pop = cpl_valid && cpl_taken;
	assign wr_idx = pop ? count - CW'(1) : count;
	assign next_count = count + CW'(push) - CW'(pop);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count <= '0;
			cpl_ready <= 1'b1;
			cpl_valid <= 1'b0;
		end
		else
		begin
			count <= next_count;
			cpl_ready <= next_count < CW'(DEPTH);
			cpl_valid <= next_count != '0;
		end
	end

	// shift queue so that entry zero drives the outputs from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				q_hdr[i] <= '0;
				q_kind[i] <= CPL_UNSUPPORTED;
			end
		end
		else
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				if (push && wr_idx == CW'(i))
				begin
					q_hdr[i] <= cpl_header_info;
					q_kind[i] <= cpl_kind;
				end
				else if (pop && i < DEPTH - 1)
				begin
					q_hdr[i] <= q_hdr[i + 1];
					q_kind[i] <= q_kind[i + 1];
				end
			end
		end
	end

	assign cpl_header = q_hdr[0];
	assign cpl_status = q_kind[0];

	// header log: first uncorrectable error under AER wins until its bit clears
	assign log_now = aer && !header_logged && unc_hit != 32'h0000_0000;
	assign log_clear = header_logged && paddr == `REG_UNC_STATUS && w1c[first_ptr];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			header_logged <= 1'b0;
			first_ptr <= 5'h00;
			hdr_log <= '0;
		end
		else if (log_now)
		begin
			header_logged <= 1'b1;
			first_ptr <= hit_ptr;
			hdr_log <= tlp_header_log;
		end
		else if (log_clear)
			header_logged <= 1'b0;
	end

	// sticky status; a new event wins over a same-cycle software clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dev_status <= 5'h00;
			unc_status <= 32'h0000_0000;
			cor_status <= 32'h0000_0000;
		end
		else
		begin
			if (paddr == `REG_DEV_STATUS)
				dev_status <= (dev_status & ~w1c[4:0]) | dev_hit;
			else
				dev_status <= dev_status | dev_hit;
			if (wake_request_pulse && pme_enable && power_state != `PWR_D0)
				dev_status[`DEV_PME] <= 1'b1;
			if (paddr == `REG_UNC_STATUS)
				unc_status <= (unc_status & ~w1c) | unc_hit;
			else
				unc_status <= unc_status | unc_hit;
			if (paddr == `REG_COR_STATUS)
				cor_status <= (cor_status & ~w1c) | cor_hit;
			else
				cor_status <= cor_status | cor_hit;
		end
	end

	// writable configuration; power state is written by the host side
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= `CTRL_RESET;
			unc_mask <= 32'h0000_0000;
			unc_severity <= 32'h0000_0000;
			cor_mask <= 32'h0000_0000;
		end
		else if (wr_en)
		begin
			if (paddr == `REG_CTRL)
				ctrl <= pwdata;
			else if (paddr == `REG_UNC_MASK)
				unc_mask <= pwdata;
			else if (paddr == `REG_UNC_SEVERITY)
				unc_severity <= pwdata;
			else if (paddr == `REG_COR_MASK)
				cor_mask <= pwdata;
		end
	end

	// power state seen by the user logic before it reports
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			power_state <= `PWR_D0;
			pme_enable <= 1'b0;
		end
		else
		begin
			power_state <= ctrl[`CTRL_PWR_HI:`CTRL_PWR_LO];
			pme_enable <= ctrl[`CTRL_PME_EN];
		end
	end

	// apb slave: one wait state, read data and error registered with pready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (psel && penable && !pready)
			begin
				if (paddr == `REG_CTRL)
					prdata <= ctrl;
				else if (paddr == `REG_DEV_STATUS)
					prdata <= {27'h0000000, dev_status};
				else if (paddr == `REG_UNC_STATUS)
					prdata <= unc_status;
				else if (paddr == `REG_UNC_MASK)
					prdata <= unc_mask;
				else if (paddr == `REG_UNC_SEVERITY)
					prdata <= unc_severity;
				else if (paddr == `REG_COR_STATUS)
					prdata <= cor_status;
				else if (paddr == `REG_COR_MASK)
					prdata <= cor_mask;
				else if (paddr == `REG_LOG_CTRL)
					prdata <= {23'h000000, header_logged, 3'h0, first_ptr};
				else if (paddr >= `REG_HDR_LOG0 && paddr <= `REG_HDR_LOG3 && paddr[1:0] == 2'b00)
					prdata <= hdr_log[paddr[3:2] * 32 +: 32];
				else
					pslverr <= 1'b1; // unmapped: error, reads zero
			end
		end
	end
endmodule : err_report

// ==== verif/err_report_monitor.sv ====
`timescale 1ns/1ps
`include "err_report_consts.svh"
module err_report_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic report_unsupported_request,
	input wire logic report_completer_abort,
	input wire logic report_unexpected_cpl,
	input wire logic report_malformed,
	input wire logic error_posted,
	input wire logic [47:0] cpl_header_info,
	input wire logic cpl_ready,
	input wire logic [1:0] power_state,
	input wire logic cpl_valid,
	input wire err_report_pkg::cpl_status_e cpl_status,
	input wire logic [47:0] cpl_header,
	input wire logic cpl_taken,
	input wire logic msg_valid,
	input wire err_report_pkg::msg_kind_e msg_kind
);
	import err_report_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// only an empty queue, or a lone entry popped in the same cycle, shows the new entry at its head next cycle
	sequence np_push(s);
		s && !error_posted && cpl_ready && !cpl_valid;
	endsequence
	sequence ctrl_write;
		psel && penable && pready && pwrite && paddr == `REG_CTRL;
	endsequence
	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	a_ur_cpl: assert property (np_push(report_unsupported_request) |=> cpl_valid
		&& cpl_status == CPL_UNSUPPORTED && cpl_header == $past(cpl_header_info))
		else $error("unsupported completion wrong");
	a_ca_cpl: assert property (np_push(report_completer_abort) |=> cpl_valid
		&& cpl_status == CPL_ABORT) else $error("abort completion wrong");
	a_posted_nocpl: assert property (report_unsupported_request && error_posted
		&& !cpl_valid |=> !cpl_valid) else $error("posted error got completion");
	a_cpl_hold: assert property (cpl_valid && !cpl_taken |=> cpl_valid
		&& $stable(cpl_header)) else $error("completion head lost");
	a_ready_full: assert property (!cpl_ready |-> cpl_valid)
		else $error("ready low with empty queue");
	a_adv_silent: assert property (report_unexpected_cpl |=>
		!msg_valid || msg_kind == MSG_CORRECTABLE) else $error("advisory sent uncorrectable");
	a_mal_kind: assert property (report_malformed |=>
		!msg_valid || msg_kind != MSG_CORRECTABLE) else $error("malformed sent correctable");
	a_pwr_copy: assert property (ctrl_write |=> ##1 power_state == $past(pwdata[9:8], 2))
		else $error("power state not copied");
endmodule : err_report_monitor

// ==== verif/err_user_model.sv ====
`timescale 1ns/1ps
module err_user_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic [3:0] kind,
	input wire logic posted,
	input wire logic no_rec,
	input wire logic [47:0] info,
	input wire logic [127:0] hdr,
	input wire logic [1:0] power_state,
	input wire logic pme_enable,
	input wire logic cpl_ready,
	output logic busy,
	output logic [9:0] strobe,
	output logic error_posted,
	output logic error_no_recovery,
	output logic [47:0] cpl_header_info,
	output logic [127:0] tlp_header_log,
	output logic wake_request_pulse
);
	logic [3:0] k;
	logic p;
	logic nr;
	logic woke;
	logic [47:0] inf;
	// one error in flight; it waits for D0 and, for UR or abort, for queue room
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy <= 1'b0;
			strobe <= '0;
			wake_request_pulse <= 1'b0;
			woke <= 1'b0;
			error_posted <= 1'b0;
			error_no_recovery <= 1'b0;
			cpl_header_info <= '0;
			tlp_header_log <= '0;
		end
		else
		begin
			strobe <= '0;
			wake_request_pulse <= 1'b0;
			// released qualifiers show the inverse, never a stale match
			if (|strobe)
			begin
				error_posted <= ~error_posted;
				error_no_recovery <= ~error_no_recovery;
				cpl_header_info <= ~cpl_header_info;
			end
			if (go)
			begin
				busy <= 1'b1;
				woke <= 1'b0;
				k <= kind;
				p <= posted;
				nr <= no_rec;
				inf <= info;
			end
			else if (busy && power_state != 2'b00)
			begin
				wake_request_pulse <= pme_enable && !woke;
				woke <= woke || pme_enable;
			end
			else if (busy && (k > 4'd1 || cpl_ready))
			begin
				strobe <= 10'b1 << k;
				error_posted <= p;
				error_no_recovery <= nr;
				cpl_header_info <= inf;
				tlp_header_log <= hdr;
				busy <= 1'b0;
			end
		end
	end
endmodule : err_user_model

// ==== verif/tb_err_report.sv ====
`timescale 1ns/1ps
`include "err_report_consts.svh"
module tb_err_report;
	import err_report_pkg::*;
	logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, cpl_taken = 0, go = 0;
	logic [7:0] paddr = 0, seq = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, error_posted, error_no_recovery, wake_request_pulse, cpl_ready;
	logic header_logged, pme_enable, cpl_valid, msg_valid, busy, posted = 0, no_rec = 0;
	logic [9:0] strobe;
	logic [3:0] kind = 0;
	logic [47:0] cpl_header_info, cpl_header, info = 0;
	logic [127:0] tlp_header_log, hdr = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
	logic [1:0] power_state, msg_k;
	cpl_status_e cpl_status;
	msg_kind_e msg_kind;
	int err_count = 0, checked = 0, msg_n = 0, cyc = 0;

	err_report #(.DEPTH(4)) err_report_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .report_unsupported_request(strobe[0]),
		.report_completer_abort(strobe[1]), .report_cpl_timeout(strobe[2]),
		.report_unexpected_cpl(strobe[3]), .report_atomic_egress_block(strobe[4]),
		.report_multicast_block(strobe[5]), .report_ecrc(strobe[6]),
		.report_correctable(strobe[7]), .report_malformed(strobe[8]),
		.report_poisoned(strobe[9]), .error_posted, .error_no_recovery, .cpl_header_info,
		.tlp_header_log, .wake_request_pulse, .cpl_ready, .header_logged, .power_state,
		.pme_enable, .cpl_valid, .cpl_status, .cpl_header, .cpl_taken, .msg_valid, .msg_kind);
	err_user_model err_user_model_i (.pclk, .presetn, .go, .kind, .posted, .no_rec, .info,
		.hdr, .power_state, .pme_enable, .cpl_ready, .busy, .strobe, .error_posted,
		.error_no_recovery, .cpl_header_info, .tlp_header_log, .wake_request_pulse);

	initial
	begin
		forever #2.5 pclk = ~pclk;
	end
	// messages are counted, so a scenario compares deltas without a second driver
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (msg_valid === 1'b1)
		begin
			msg_n <= msg_n + 1;
			msg_k <= msg_kind;
		end
		if (cyc == 20000)
		begin
			err_count++;
			complete_run;
		end
	end

	task automatic check(input string n, input logic [63:0] s, input logic [63:0] x);
		checked++;
		if (s !== x)
		begin
			err_count++;
			$display("BAD %s exp %h seen %h", n, x, s);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic issue(input logic [3:0] k, input logic p, input logic nr);
		kind <= k;
		posted <= p;
		no_rec <= nr;
		info <= {32'h5A5A_0000, 4'h0, seq, k};
		seq = seq + 8'h01;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
	endtask : issue
	task automatic pop(input logic s, input logic [47:0] h);
		check("status", cpl_status, s);
		check("header", cpl_header, h);
		cpl_taken <= 1'b1;
		@(posedge pclk);
		cpl_taken <= 1'b0;
		@(posedge pclk);
	endtask : pop
	// code byte: kind, posted, no-recovery, message kind (3 = none)
	task automatic judge(input logic [7:0] c, input int n0);
		logic np;
		np = c[7:5] == 3'h0 && !c[3];
		while (busy !== 1'b0)
			@(posedge pclk);
		repeat (3) @(posedge pclk);
		check("msg", msg_n == n0 ? 2'h3 : msg_k, c[1:0]);
		check("cpl", cpl_valid, np);
		if (np)
			pop(c[4], info);
	endtask : judge
	task automatic send(input logic [7:0] c);
		int n0;
		n0 = msg_n;
		issue(c[7:4], c[3], c[2]);
		judge(c, n0);
	endtask : send
	task automatic t_plain;
		logic [7:0] t[13] = '{8'h03, 8'h09, 8'h11, 8'h23, 8'h25, 8'h3B, 8'h43, 8'h59, 8'h69,
			8'h70, 8'h82, 8'h9B, 8'h9D};
		logic [31:0] r;
		logic e;
		check("ready", cpl_ready, 1);
		apb(1'b0, 8'h40, 32'h0, r, e);
		check("unmapped", {e, r}, 33'h1_0000_0000);
		wr(`REG_CTRL, 32'h0000_000E);
		foreach (t[i])
			send(t[i]);
		$display("plain table done");
	endtask : t_plain
	task automatic t_aer;
		logic [7:0] t[10] = '{8'h00, 8'h09, 8'h10, 8'h20, 8'h38, 8'h40, 8'h59, 8'h70, 8'h81,
			8'h98};
		logic [7:0] u[3] = '{8'h0A, 8'h82, 8'h5A};
		logic [31:0] r;
		logic e;
		wr(`REG_CTRL, 32'h0000_000F);
		foreach (t[i])
			send(t[i]);
		check("logged", header_logged, 1);
		apb(1'b0, `REG_HDR_LOG0, 32'h0, r, e);
		check("log0", r, hdr[31:0]);
		apb(1'b0, `REG_LOG_CTRL, 32'h0, r, e);
		check("log_ctrl", r, (32'h1 << `LOG_SET_BIT) | `UNC_UR);
		wr(`REG_UNC_SEVERITY, 32'hFFFF_FFFF);
		check("log_held", header_logged, 1);
		foreach (u[i])
			send(u[i]);
		wr(`REG_UNC_SEVERITY, 32'h0);
		wr(`REG_COR_MASK, 32'h0000_2000);
		send(8'h3B);
		wr(`REG_UNC_MASK, 32'h0010_0000);
		send(8'h0B);
		wr(`REG_UNC_MASK, 32'h0);
		// clearing the first pointer's status bit frees the header log
		wr(`REG_UNC_STATUS, 32'h0010_0000);
		check("log_free", header_logged, 0);
		// serr enable alone still lets a non-fatal message out
		wr(`REG_CTRL, 32'h0000_0010);
		send(8'h09);
		// enables off: no message, yet the status bit still sets
		wr(`REG_CTRL, 32'h0);
		wr(`REG_DEV_STATUS, 32'h0000_001F);
		send(8'h0B);
		apb(1'b0, `REG_DEV_STATUS, 32'h0, r, e);
		check("ur_status", r[`DEV_UR], 1);
		$display("aer table done");
	endtask : t_aer
	task automatic t_full;
		logic [7:0] s0;
		s0 = seq;
		repeat (4)
		begin
			issue(4'h0, 1'b0, 1'b0);
			while (busy !== 1'b0)
				@(posedge pclk);
		end
		repeat (2) @(posedge pclk);
		check("full", cpl_ready, 0);
		issue(4'h0, 1'b0, 1'b0);
		repeat (6) @(posedge pclk);
		check("waiting", busy, 1);
		for (int i = 0; i < 5; i++)
		begin
			if (i == 4)
				repeat (4) @(posedge pclk);
			pop(1'b0, {32'h5A5A_0000, 4'h0, s0 + 8'(i), 4'h0});
		end
		$display("queue full done");
	endtask : t_full
	task automatic t_power;
		logic [31:0] r;
		logic e;
		int n0;
		wr(`REG_CTRL, 32'h0000_0506);
		n0 = msg_n;
		issue(4'h0, 1'b1, 1'b0);
		repeat (8) @(posedge pclk);
		check("held", busy, 1);
		apb(1'b0, `REG_DEV_STATUS, 32'h0, r, e);
		check("pme", r[`DEV_PME], 1);
		wr(`REG_CTRL, 32'h0000_0006);
		judge(8'h09, n0);
		$display("power state done");
	endtask : t_power
	task automatic complete_run;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	initial
	begin
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_plain;
		t_aer;
		t_full;
		t_power;
		complete_run;
	end
endmodule : tb_err_report

bind err_report err_report_monitor err_report_monitor_i (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .report_unsupported_request, .report_completer_abort,
	.report_unexpected_cpl, .report_malformed, .error_posted, .cpl_header_info, .cpl_ready,
	.power_state, .cpl_valid, .cpl_status, .cpl_header, .cpl_taken, .msg_valid, .msg_kind);
